// *** common/spfd_cfg.svh ***
// Constants for the slave parameter frame decoder
`ifndef SPFD_CFG_SVH
`define SPFD_CFG_SVH
`define SPFD_FRAME_LEN      3'h5
`define SPFD_IDX_OPTION     3'h0
`define SPFD_IDX_MASK       3'h1
`define SPFD_IDX_MASK2      3'h2
`define SPFD_IDX_SPARE_A    3'h3
`define SPFD_IDX_SPARE_B    3'h4
`define SPFD_BIT_WATCHDOG_TIMEBASE_SELECT    2
`define SPFD_BIT_GRP_QUAL   3
`define SPFD_OPT_RSVD_MASK  8'hf3
`define SPFD_OPT_RESET      8'h00
`define SPFD_MASK_RESET     8'h00
`define SPFD_CLK_HZ         20000000
`define SPFD_BASE_SLOW_US   10000
`define SPFD_BASE_FAST_US   1000
`define SPFD_SLOW_CYC  ((`SPFD_CLK_HZ / 1000000) * `SPFD_BASE_SLOW_US)
`define SPFD_FAST_CYC  ((`SPFD_CLK_HZ / 1000000) * `SPFD_BASE_FAST_US)
`endif

// *** common/spfd_pkg.sv ***
// Types for the slave parameter frame decoder
package spfd_pkg;
  typedef enum logic [1:0] {
    SPFD_IDLE = 2'b00,
    SPFD_RECV = 2'b01,
    SPFD_DONE = 2'b10
  } spfd_state_t;
endpackage : spfd_pkg

// *** hw/spfd_tick_gen.sv ***
// Watchdog time base tick generator
`timescale 1ns/10ps
`include "spfd_cfg.svh"
module spfd_tick_gen #(
  parameter int unsigned SLOW_CYC = `SPFD_SLOW_CYC,
  parameter int unsigned FAST_CYC = `SPFD_FAST_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Control
  input  wire logic i_fast,
  // Tick
  output logic      o_tick
);
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic        tick_d;
  logic        tick_q;
  logic [19:0] limit;

  always_comb begin
    limit  = i_fast ? 20'(FAST_CYC - 1) : 20'(SLOW_CYC - 1);
    tick_d = 1'b0;
    cnt_d  = cnt_q + 20'h00001;
    if (cnt_q >= limit) begin
      cnt_d  = 20'h00000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q  <= 20'h00000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule : spfd_tick_gen

// *** hw/spfd_decoder.sv ***
// Parameter frame decoder: collects five bytes, applies them at frame end
`timescale 1ns/10ps
`include "spfd_cfg.svh"

// Operation
// - Byte 0 bit 2 picks the watchdog base, 0 = 10 ms (reset), 1 = 1 ms.
// - With byte 0 bit 3 clear the group diagnostic error is always shown.
// - With bit 3 set it is shown only when a channel error is present.
// - A one in mask byte 1 hides the same bit of the channel diagnostic.
// - Reset clears every channel diagnostic mask bit.
// - The frame is accepted only after a matching configuration.
module spfd_decoder
  import spfd_pkg::*;
#(
  parameter int unsigned SLOW_CYC = `SPFD_SLOW_CYC,
  parameter int unsigned FAST_CYC = `SPFD_FAST_CYC,
  parameter bit          IS_INPUT = 1'b0
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Configuration check result
  input  wire logic       i_cfg_match,
  // Parameter byte stream
  input  wire logic       i_prm_start,
  input  wire logic       i_prm_valid,
  input  wire logic [7:0] i_prm_byte,
  // Channel diagnostics
  input  wire logic [7:0] i_chan_diag,
  // Results
  output logic            o_cfg_ok,
  output logic            o_prm_done,
  output logic            o_prm_error,
  output logic            o_watchdog_timebase_select,
  output logic            o_wd_tick,
  output logic [7:0]      o_channel_diag_mask,
  output logic [7:0]      o_chan_diag_rep,
  output logic            o_group_diag
);
  spfd_state_t st_q;
  spfd_state_t st_d;
  logic [2:0]  idx_q;
  logic [2:0]  idx_d;
  logic [7:0]  opt_sh_q;
  logic [7:0]  opt_sh_d;
  logic [7:0]  msk_sh_q;
  logic [7:0]  msk_sh_d;
  logic        err_sh_q;
  logic        err_sh_d;
  logic [7:0]  opt_q;
  logic [7:0]  opt_d;
  logic [7:0]  msk_q;
  logic [7:0]  msk_d;
  logic        cfg_q;
  logic        cfg_d;
  logic        done_q;
  logic        done_d;
  logic        perr_q;
  logic        perr_d;
  logic [7:0]  rep_q;
  logic [7:0]  rep_d;
  logic        grp_q;
  logic        grp_d;
  logic        byte_bad;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    byte_bad = 1'b0;
    case (idx_q)
      `SPFD_IDX_OPTION: begin
        byte_bad = |(i_prm_byte & `SPFD_OPT_RSVD_MASK);
        if (IS_INPUT && i_prm_byte[`SPFD_BIT_GRP_QUAL]) begin
          byte_bad = 1'b1;
        end
      end
      `SPFD_IDX_MASK: byte_bad = IS_INPUT && (|i_prm_byte);
      default: byte_bad = |i_prm_byte;
    endcase
  end

  always_comb begin
    st_d     = st_q;
    idx_d    = idx_q;
    opt_sh_d = opt_sh_q;
    msk_sh_d = msk_sh_q;
    err_sh_d = err_sh_q;
    opt_d    = opt_q;
    msk_d    = msk_q;
    perr_d   = perr_q;
    done_d   = 1'b0;
    cfg_d    = cfg_q | i_cfg_match;
    case (st_q)
      SPFD_IDLE, SPFD_DONE: begin
        if (i_prm_start && cfg_q) begin
          st_d     = SPFD_RECV;
          idx_d    = `SPFD_IDX_OPTION;
          err_sh_d = 1'b0;
        end
      end
      SPFD_RECV: begin
        if (i_prm_start) begin
          idx_d    = `SPFD_IDX_OPTION;
          err_sh_d = 1'b0;
        end else if (i_prm_valid) begin
          if (idx_q == `SPFD_IDX_OPTION) begin
            opt_sh_d = i_prm_byte;
          end
          if (idx_q == `SPFD_IDX_MASK) begin
            msk_sh_d = i_prm_byte;
          end
          err_sh_d = err_sh_q | byte_bad;
          idx_d    = idx_q + 3'h1;
          if (idx_q == `SPFD_FRAME_LEN - 3'h1) begin
            // Shadow is copied only once the frame is whole
            st_d   = SPFD_DONE;
            opt_d  = opt_sh_q;
            msk_d  = msk_sh_q;
            done_d = 1'b1;
            perr_d = err_sh_q | byte_bad;
          end
        end
      end
      default: st_d = SPFD_IDLE;
    endcase
  end

  // Group diagnostic qualification and channel masking
  always_comb begin
    rep_d = i_chan_diag & ~msk_q;
    if (opt_q[`SPFD_BIT_GRP_QUAL]) begin
      grp_d = |rep_d;
    end else begin
      grp_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q     <= SPFD_IDLE;
      idx_q    <= `SPFD_IDX_OPTION;
      opt_sh_q <= `SPFD_OPT_RESET;
      msk_sh_q <= `SPFD_MASK_RESET;
      err_sh_q <= 1'b0;
      opt_q    <= `SPFD_OPT_RESET;
      msk_q    <= `SPFD_MASK_RESET;
      cfg_q    <= 1'b0;
      done_q   <= 1'b0;
      perr_q   <= 1'b0;
      rep_q    <= 8'h00;
      grp_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      idx_q    <= idx_d;
      opt_sh_q <= opt_sh_d;
      msk_sh_q <= msk_sh_d;
      err_sh_q <= err_sh_d;
      opt_q    <= opt_d;
      msk_q    <= msk_d;
      cfg_q    <= cfg_d;
      done_q   <= done_d;
      perr_q   <= perr_d;
      rep_q    <= rep_d;
      grp_q    <= grp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  spfd_tick_gen #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_fast  (opt_q[`SPFD_BIT_WATCHDOG_TIMEBASE_SELECT]),
    .o_tick  (o_wd_tick)
  );

  assign o_cfg_ok                   = cfg_q;
  assign o_prm_done                 = done_q;
  assign o_prm_error                = perr_q;
  assign o_watchdog_timebase_select = opt_q[`SPFD_BIT_WATCHDOG_TIMEBASE_SELECT];
  assign o_channel_diag_mask        = msk_q;
  assign o_chan_diag_rep            = rep_q;
  assign o_group_diag               = grp_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_MASK_APPLIED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_chan_diag_rep == ($past(i_chan_diag) & ~$past(msk_q)))
    else $error("masked channel diag wrong");
  // Group flag is still the reset zero on the first edge after release
  AST_GROUP_ALWAYS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_rst_b) && !$past(opt_q[`SPFD_BIT_GRP_QUAL]) |-> o_group_diag)
    else $error("group diag not forced");
  AST_GROUP_QUAL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(opt_q[`SPFD_BIT_GRP_QUAL]) |-> o_group_diag == |o_chan_diag_rep)
    else $error("qualified group diag wrong");
  AST_HOLD_UNTIL_DONE: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    !done_d |=> $stable(msk_q) && $stable(opt_q))
    else $error("values changed mid frame");
  AST_DONE_APPLIES: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    done_d |=> o_prm_done && o_channel_diag_mask == $past(msk_sh_q))
    else $error("frame end did not apply mask");
  AST_RESET_CLEAR: assert property (@(posedge i_clk)
    !i_rst_b |=> o_channel_diag_mask == 8'h00 && !o_watchdog_timebase_select)
    else $error("reset defaults wrong");
  AST_NEED_CFG: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_q == SPFD_IDLE && !cfg_q) |=> st_q == SPFD_IDLE)
    else $error("frame taken without config");
  AST_WD_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    done_d |=> o_watchdog_timebase_select ==
      $past(opt_sh_q[`SPFD_BIT_WATCHDOG_TIMEBASE_SELECT]))
    else $error("time base select wrong");
  COV_FRAME: cover property (@(posedge i_clk) o_prm_done && !o_prm_error);
  COV_BAD: cover property (@(posedge i_clk) o_prm_done && o_prm_error);
  COV_FAST: cover property (@(posedge i_clk) o_watchdog_timebase_select);
endmodule : spfd_decoder

// *** bench/spfd_master_model.sv ***
// Behavioural fieldbus master that sends one parameter frame on request
`timescale 1ns/10ps
module spfd_master_model #(
  // One millisecond of 50 ns cycles between accesses
  parameter int unsigned GAP_CYC = 20000
) (
  // Bench control
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic        i_cfg_good,
  input  wire logic [39:0] i_frame,
  // Link side
  output logic             o_cfg_match,
  output logic             o_prm_start,
  output logic             o_prm_valid,
  output logic [7:0]       o_prm_byte,
  output logic             o_busy
);
  initial begin
    {o_cfg_match, o_prm_start, o_prm_valid, o_busy} = 4'h0;
    o_prm_byte = 8'h5a;
  end
  // Low i_cfg_good still sends the frame: a misbehaviour the bench asks for
  always begin
    @(posedge i_clk);
    if (i_go) begin
      o_busy      <= 1'b1;
      o_cfg_match <= i_cfg_good;
      @(posedge i_clk);
      o_cfg_match <= 1'b0;
      o_prm_start <= 1'b1;
      @(posedge i_clk);
      o_prm_start <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        o_prm_valid <= 1'b1;
        o_prm_byte  <= i_frame[39 - 8 * i -: 8];
        @(posedge i_clk);
        o_prm_valid <= 1'b0;
        // Released byte lane never shows stale data
        o_prm_byte  <= ~o_prm_byte;
        @(posedge i_clk);
      end
      repeat (GAP_CYC) @(posedge i_clk);
      o_busy <= 1'b0;
    end
  end
endmodule : spfd_master_model

// *** bench/slave_parameter_frame_decoder_tb.sv ***
// Self-checking bench for the parameter frame decoder
`timescale 1ns/10ps
module slave_parameter_frame_decoder_tb;
  logic        i_clk, i_rst_b, go, cfg_good, cfg_match, prm_start;
  logic        prm_valid, busy, cfg_ok, prm_done, prm_error;
  logic        wd_sel, wd_tick, group_diag, in_error;
  logic [39:0] frame;
  logic [7:0]  prm_byte, chan_diag, diag_mask, diag_rep;
  int          err_count, check_count, cyc, done_cnt;

  always #25 i_clk = ~i_clk;

  spfd_master_model #(.GAP_CYC(20000)) master_u (.i_clk(i_clk), .i_go(go),
    .i_cfg_good(cfg_good), .i_frame(frame), .o_cfg_match(cfg_match),
    .o_prm_start(prm_start), .o_prm_valid(prm_valid),
    .o_prm_byte(prm_byte), .o_busy(busy));

  // Short base periods keep the tick checks quick
  spfd_decoder #(.SLOW_CYC(20), .FAST_CYC(4), .IS_INPUT(1'b0)) dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_match(cfg_match),
    .i_prm_start(prm_start), .i_prm_valid(prm_valid),
    .i_prm_byte(prm_byte), .i_chan_diag(chan_diag), .o_cfg_ok(cfg_ok),
    .o_prm_done(prm_done), .o_prm_error(prm_error),
    .o_watchdog_timebase_select(wd_sel), .o_wd_tick(wd_tick),
    .o_channel_diag_mask(diag_mask), .o_chan_diag_rep(diag_rep),
    .o_group_diag(group_diag));

  // Input-module variant sees the same frames, only its error flag is used
  spfd_decoder #(.SLOW_CYC(20), .FAST_CYC(4), .IS_INPUT(1'b1)) dut_in_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_match(cfg_match),
    .i_prm_start(prm_start), .i_prm_valid(prm_valid),
    .i_prm_byte(prm_byte), .i_chan_diag(chan_diag), .o_cfg_ok(),
    .o_prm_done(), .o_prm_error(in_error),
    .o_watchdog_timebase_select(), .o_wd_tick(),
    .o_channel_diag_mask(), .o_chan_diag_rep(),
    .o_group_diag());

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task send(input logic [39:0] f, input logic good);
    logic [7:0] old;
    old = diag_mask;
    done_cnt = 0;
    @(posedge i_clk);
    frame    <= f;
    cfg_good <= good;
    go       <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    for (int n = 0; n < 21000 && busy; n++) begin
      @(posedge i_clk);
      #1;
      if (prm_done === 1'b1) begin
        done_cnt++;
        old = diag_mask;
      end
      check(diag_mask, old);
    end
  endtask : send

  task diag(input logic [7:0] d, input logic [7:0] rep, input logic grp);
    @(posedge i_clk);
    chan_diag <= d;
    repeat (2) @(posedge i_clk);
    #1;
    check(diag_rep, rep);
    check(8'(group_diag), 8'(grp));
  endtask : diag

  // First two intervals only sync to the tick train
  task period(input int exp);
    int c;
    repeat (3) begin
      c = 0;
      do begin
        @(posedge i_clk);
        #1;
        c++;
      end while (wd_tick !== 1'b1 && c < 100);
    end
    check(8'(c), 8'(exp));
  endtask : period

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    i_clk     = 1'b0;
    i_rst_b   = 1'b0;
    go        = 1'b0;
    cfg_good  = 1'b0;
    frame     = 40'h0;
    chan_diag = 8'h00;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check(8'(wd_sel), 8'h00);
    check(diag_mask, 8'h00);
    check(8'(group_diag), 8'h01);
    period(20);
    $display("test reset defaults ended");
    send(40'h0ca3000000, 1'b0);
    check(8'(done_cnt), 8'h00);
    check(8'(cfg_ok), 8'h00);
    check(diag_mask, 8'h00);
    $display("test refused frame ended");
    send(40'h0ca3000000, 1'b1);
    check(8'(done_cnt), 8'h01);
    check(8'(wd_sel), 8'h01);
    check(diag_mask, 8'ha3);
    check(8'(prm_error), 8'h00);
    check(8'(in_error), 8'h01);
    period(4);
    diag(8'hff, 8'h5c, 1'b1);
    diag(8'ha3, 8'h00, 1'b0);
    $display("test qualified frame ended");
    send(40'h01ff000100, 1'b1);
    check(8'(prm_error), 8'h01);
    check(8'(wd_sel), 8'h00);
    diag(8'hff, 8'h00, 1'b1);
    send(40'h0000000000, 1'b1);
    check(8'(prm_error), 8'h00);
    check(8'(in_error), 8'h00);
    diag(8'h00, 8'h00, 1'b1);
    $display("test unqualified frames ended");
    print_verdict();
  end
endmodule : slave_parameter_frame_decoder_tb
